// ===== ddr_dev_end.sv
// Memory device end of the DDR link: command capture, core, data
`timescale 1ns/100ps
module ddr_dev_end #(
  parameter int NUM_BANKS = 8,
  parameter int BURST_LEN = 4,
  parameter int RD_LAT = 2,
  parameter int COL_WORDS = 4
) (
  ddr_link_if.dev lnk,
  input wire logic i_clk,
  input wire logic i_srst,
  output logic o_power_down,
  output logic o_cmd_valid,
  output ddr_link_pkg::cmd_e o_cmd,
  output logic [ddr_link_pkg::BANK_W-1:0] o_cmd_bank,
  output logic [ddr_link_pkg::ROW_W-1:0] o_cmd_addr
);
  localparam int CA_W = ddr_link_pkg::CA_W;
  localparam int DQ_W = ddr_link_pkg::DQ_W;
  localparam int LANES = ddr_link_pkg::LANES;
  localparam int BANK_W = ddr_link_pkg::BANK_W;
  localparam int COL_W = ddr_link_pkg::COL_W;
  localparam int SLOT_W = ddr_link_pkg::SLOT_W;
  localparam int WORD_W = ddr_link_pkg::WORD_W;
  localparam int BYTE_W = ddr_link_pkg::BYTE_W;
  localparam int WORDS = NUM_BANKS * COL_WORDS;
  localparam int IDX_W = $clog2(WORDS);
  localparam int BEAT_W = $clog2(BURST_LEN + 1);
  localparam int CNT_W = $clog2(2 * RD_LAT);
  localparam logic [BANK_W-1:0] BANK_MASK = BANK_W'(NUM_BANKS - 1);
  localparam logic [BEAT_W-1:0] BEAT_END = BEAT_W'(BURST_LEN);
  localparam logic [CNT_W-1:0] RD_WAIT_EDGES = CNT_W'(2 * RD_LAT - 2);
  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(ddr_link_pkg::BEATS_PER_WORD - 1);

  typedef struct packed {
    logic ck;
    logic cke;
    logic cs_n;
    logic dqs;
    logic [CA_W-1:0] ca;
    logic [LANES-1:0] dm;
    logic [DQ_W-1:0] dq;
  } pin_s;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_RWAIT = 3'h1,
    D_RPRE = 3'h2,
    D_RDATA = 3'h3,
    D_WDATA = 3'h4
  } dstate_e;

  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] col,
    input logic [BEAT_W-1:0] beat
  );
    logic [COL_W-1:0] wrap;
    wrap = COL_W'(BURST_LEN - 1);
    burst_col = (col & ~wrap) | ((col + COL_W'(beat)) & wrap);
  endfunction : burst_col

  function automatic logic [IDX_W-1:0] word_idx(
    input logic [BANK_W-1:0] bank,
    input logic [COL_W-1:0] col
  );
    word_idx = IDX_W'(int'(bank) * COL_WORDS
      + int'(col[COL_W-1:SLOT_W]) % COL_WORDS);
  endfunction : word_idx

  pin_s pin_in, s1_r, s2_r;
  logic ck_prev_r, dqs_prev_r;
  logic ck_rise, ck_fall, ck_edge, dqs_edge;
  logic cke_r, cke_nxt, cke_last_r, cke_last_nxt, cs_n_r, cs_n_nxt;
  logic [CA_W-1:0] ca_hi_r, ca_hi_nxt;
  ddr_link_pkg::cmd_e op;
  logic [BANK_W-1:0] cmd_bank;
  logic fire;
  logic ov_r, ov_nxt;
  ddr_link_pkg::cmd_e oc_r, oc_nxt;
  logic [BANK_W-1:0] ob_r, ob_nxt;
  logic [ddr_link_pkg::ROW_W-1:0] oa_r, oa_nxt;
  dstate_e dst_r, dst_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [BEAT_W-1:0] beat_r, beat_nxt;
  logic [BANK_W-1:0] bank_r, bank_nxt;
  logic [COL_W-1:0] col_r, col_nxt, bc;
  logic [SLOT_W-1:0] slot;
  logic [WORD_W-1:0] rword, wbuf_r, wbuf_nxt;
  logic [ddr_link_pkg::WORD_BYTES-1:0] wmask_r, wmask_nxt;
  logic [DQ_W-1:0] dq_r, dq_nxt;
  logic dqs_r, dqs_nxt, oe_r, oe_nxt;
  logic wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic [WORD_W-1:0] mem_r [WORDS];
  logic [WORD_W-1:0] mem_nxt [WORDS];

  // Each sampled pin crosses two flops; CA and strobe keep the clock's lag
  assign pin_in = {lnk.ck_t, lnk.cke, lnk.cs_n, lnk.dqs_t[0],
    lnk.ca, lnk.dm, lnk.dq};
  assign ck_rise = s2_r.ck & ~ck_prev_r;
  assign ck_fall = ~s2_r.ck & ck_prev_r;
  assign ck_edge = ck_rise | ck_fall;
  // Lanes share one strobe timing, so lane 0 paces the capture
  assign dqs_edge = s2_r.dqs ^ dqs_prev_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      s1_r <= '0;
      s2_r <= '0;
      ck_prev_r <= 1'b0;
      dqs_prev_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      ck_prev_r <= s2_r.ck;
      dqs_prev_r <= s2_r.dqs;
    end
  end

  always_comb begin
    cke_nxt = cke_r;
    cke_last_nxt = cke_last_r;
    cs_n_nxt = cs_n_r;
    ca_hi_nxt = ca_hi_r;
    if (ck_rise) begin
      cke_last_nxt = cke_r;
      cke_nxt = s2_r.cke;
      cs_n_nxt = s2_r.cs_n;
      ca_hi_nxt = s2_r.ca;
    end
  end

  assign op = ddr_link_pkg::cmd_e'(ca_hi_r[ddr_link_pkg::OP_LSB +: ddr_link_pkg::OP_W]);
  assign cmd_bank = ca_hi_r[ddr_link_pkg::BANK_LSB +: BANK_W] & BANK_MASK;
  // A CKE change on this rise is a power transition, not a command
  assign fire = ck_fall && !cs_n_r && cke_r && cke_last_r;

  always_comb begin
    ov_nxt = 1'b0;
    oc_nxt = oc_r;
    ob_nxt = ob_r;
    oa_nxt = oa_r;
    if (fire && op != ddr_link_pkg::CMD_NOP) begin
      ov_nxt = 1'b1;
      oc_nxt = op;
      ob_nxt = cmd_bank;
      if (op == ddr_link_pkg::CMD_ACT) begin
        oa_nxt = {ca_hi_r[ddr_link_pkg::ROWHI_LSB +: ddr_link_pkg::ROWHI_W],
          s2_r.ca};
      end else begin
        oa_nxt = ddr_link_pkg::ROW_W'(s2_r.ca);
      end
    end
  end

  always_comb begin
    dst_nxt = dst_r;
    cnt_nxt = cnt_r;
    beat_nxt = beat_r;
    bank_nxt = bank_r;
    col_nxt = col_r;
    wbuf_nxt = wbuf_r;
    wmask_nxt = wmask_r;
    dq_nxt = dq_r;
    dqs_nxt = dqs_r;
    oe_nxt = oe_r;
    wr_en = 1'b0;
    bc = burst_col(col_r, beat_r);
    slot = bc[SLOT_W-1:0];
    wr_idx = word_idx(bank_r, bc);
    rword = mem_r[wr_idx];
    case (dst_r)
      D_IDLE: begin
        bank_nxt = cmd_bank;
        col_nxt = s2_r.ca;
        beat_nxt = '0;
        wmask_nxt = '1;
        cnt_nxt = RD_WAIT_EDGES;
        if (fire && op == ddr_link_pkg::CMD_RD) begin
          dst_nxt = D_RWAIT;
        end else if (fire && op == ddr_link_pkg::CMD_WR) begin
          dst_nxt = D_WDATA;
        end
      end
      D_RWAIT: begin
        if (ck_edge && cnt_r == CNT_W'(1)) begin
          dst_nxt = D_RPRE;
          oe_nxt = 1'b1;
          dqs_nxt = 1'b0;
        end else if (ck_edge) begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      D_RPRE, D_RDATA: begin
        if (ck_edge && beat_r == BEAT_END) begin
          dst_nxt = D_IDLE;
          oe_nxt = 1'b0;
          dqs_nxt = 1'b0;
        end else if (ck_edge) begin
          dst_nxt = D_RDATA;
          dq_nxt = rword[int'(slot)*DQ_W +: DQ_W];
          dqs_nxt = (dst_r == D_RPRE) ? 1'b1 : ~dqs_r;
          beat_nxt = beat_r + 1'b1;
        end
      end
      D_WDATA: begin
        if (dqs_edge) begin
          wbuf_nxt[int'(slot)*DQ_W +: DQ_W] = s2_r.dq;
          wmask_nxt[int'(slot)*LANES +: LANES] = s2_r.dm;
          beat_nxt = beat_r + 1'b1;
          if (slot == SLOT_LAST || beat_r == BEAT_END - 1'b1) begin
            wr_en = 1'b1;
            wmask_nxt = '1;
          end
          if (beat_r == BEAT_END - 1'b1) begin
            dst_nxt = D_IDLE;
          end
        end
      end
      default: dst_nxt = D_IDLE;
    endcase
    if (!cke_r) begin
      dst_nxt = D_IDLE;
      oe_nxt = 1'b0;
      dqs_nxt = 1'b0;
      wr_en = 1'b0;
    end
  end

  always_comb begin
    logic [WORD_W-1:0] wdat;
    logic [ddr_link_pkg::WORD_BYTES-1:0] wmsk;
    mem_nxt = mem_r;
    wdat = wbuf_r;
    wmsk = wmask_r;
    wdat[int'(slot)*DQ_W +: DQ_W] = s2_r.dq;
    wmsk[int'(slot)*LANES +: LANES] = s2_r.dm;
    for (int b = 0; b < ddr_link_pkg::WORD_BYTES; b++) begin
      if (wr_en && !wmsk[b]) begin
        mem_nxt[wr_idx][b*BYTE_W +: BYTE_W] = wdat[b*BYTE_W +: BYTE_W];
      end
    end
  end

  // Array left unreset: contents are undefined until written
  always_ff @(posedge i_clk) begin
    mem_r <= mem_nxt;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cke_r <= 1'b0;
      cke_last_r <= 1'b0;
      cs_n_r <= 1'b1;
      ca_hi_r <= '0;
      ov_r <= 1'b0;
      oc_r <= ddr_link_pkg::CMD_NOP;
      ob_r <= '0;
      oa_r <= '0;
      dst_r <= D_IDLE;
      cnt_r <= '0;
      beat_r <= '0;
      bank_r <= '0;
      col_r <= '0;
      wbuf_r <= '0;
      wmask_r <= '1;
      dq_r <= '0;
      dqs_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      cke_r <= cke_nxt;
      cke_last_r <= cke_last_nxt;
      cs_n_r <= cs_n_nxt;
      ca_hi_r <= ca_hi_nxt;
      ov_r <= ov_nxt;
      oc_r <= oc_nxt;
      ob_r <= ob_nxt;
      oa_r <= oa_nxt;
      dst_r <= dst_nxt;
      cnt_r <= cnt_nxt;
      beat_r <= beat_nxt;
      bank_r <= bank_nxt;
      col_r <= col_nxt;
      wbuf_r <= wbuf_nxt;
      wmask_r <= wmask_nxt;
      dq_r <= dq_nxt;
      dqs_r <= dqs_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign lnk.dev_dq = dq_r;
  assign lnk.dev_dq_oe = oe_r;
  assign lnk.dev_dqs_t = {LANES{dqs_r}};
  assign lnk.dev_dqs_c = {LANES{~dqs_r}};
  assign lnk.dev_dqs_oe = oe_r;
  assign o_power_down = ~cke_r;
  assign o_cmd_valid = ov_r;
  assign o_cmd = oc_r;
  assign o_cmd_bank = ob_r;
  assign o_cmd_addr = oa_r;
endmodule : ddr_dev_end

// ===== ddr_link_pkg.sv
// Shared constants and types for the DDR command/data link
package ddr_link_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CK_PERIOD_NS = 80;
  localparam int CK_DIV = CK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CK_HALF = CK_DIV / 2;
  localparam int PH_W = $clog2(CK_DIV);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(CK_DIV - 1);
  localparam logic [PH_W-1:0] PH_CA_RISE = 3'h5;
  localparam logic [PH_W-1:0] PH_CA_FALL = 3'h1;
  localparam logic [PH_W-1:0] PH_DQ_A = 3'h7;
  localparam logic [PH_W-1:0] PH_DQ_B = 3'h3;
  localparam logic [PH_W-1:0] PH_DQS_A = 3'h1;
  localparam logic [PH_W-1:0] PH_DQS_B = 3'h5;
  localparam int CA_W = 10;
  localparam int DQ_W = 32;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int BEATS_PER_WORD = 4;
  localparam int SLOT_W = $clog2(BEATS_PER_WORD);
  localparam int WORD_W = DQ_W * BEATS_PER_WORD;
  localparam int WORD_BYTES = WORD_W / BYTE_W;
  localparam int BANK_W = 3;
  localparam int ROW_W = 14;
  localparam int COL_W = 10;
  localparam int OP_LSB = 0;
  localparam int OP_W = 3;
  localparam int BANK_LSB = 3;
  localparam int ROWHI_LSB = 6;
  localparam int ROWHI_W = 4;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3
  } cmd_e;
endpackage : ddr_link_pkg

// ===== ddr_link_if.sv
// Link wires between controller end and memory device end
`timescale 1ns/100ps
interface ddr_link_if;
  logic ck_t;
  logic ck_c;
  logic cke;
  logic cs_n;
  logic [ddr_link_pkg::CA_W-1:0] ca;
  logic [ddr_link_pkg::LANES-1:0] dm;
  logic [ddr_link_pkg::DQ_W-1:0] ctl_dq;
  logic [ddr_link_pkg::DQ_W-1:0] dev_dq;
  logic [ddr_link_pkg::DQ_W-1:0] dq;
  logic ctl_dq_oe;
  logic dev_dq_oe;
  logic [ddr_link_pkg::LANES-1:0] ctl_dqs_t;
  logic [ddr_link_pkg::LANES-1:0] ctl_dqs_c;
  logic [ddr_link_pkg::LANES-1:0] dev_dqs_t;
  logic [ddr_link_pkg::LANES-1:0] dev_dqs_c;
  logic [ddr_link_pkg::LANES-1:0] dqs_t;
  logic [ddr_link_pkg::LANES-1:0] dqs_c;
  logic ctl_dqs_oe;
  logic dev_dqs_oe;

  // Undriven lines read low, as a terminated bus would settle
  assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);
  assign dqs_t = dev_dqs_oe ? dev_dqs_t : (ctl_dqs_oe ? ctl_dqs_t : '0);
  assign dqs_c = dev_dqs_oe ? dev_dqs_c : (ctl_dqs_oe ? ctl_dqs_c : '0);

  modport dev (
    input ck_t, ck_c, cke, cs_n, ca, dm, dq, dqs_t, dqs_c,
    output dev_dq, dev_dq_oe, dev_dqs_t, dev_dqs_c, dev_dqs_oe
  );
  modport ctl (
    output ck_t, ck_c, cke, cs_n, ca, dm,
    output ctl_dq, ctl_dq_oe, ctl_dqs_t, ctl_dqs_c, ctl_dqs_oe,
    input dq, dqs_t, dqs_c
  );
endinterface : ddr_link_if

// ===== ddr_ctl_end.sv
// Controller end of the DDR link: makes the clock, issues commands
`timescale 1ns/100ps
module ddr_ctl_end #(
  parameter int BURST_LEN = 4,
  parameter int WR_LAT = 1
) (
  ddr_link_if.ctl lnk,
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cke_en,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire ddr_link_pkg::cmd_e i_req_cmd,
  input wire logic [ddr_link_pkg::BANK_W-1:0] i_req_bank,
  input wire logic [ddr_link_pkg::ROW_W-1:0] i_req_addr,
  input wire logic [BURST_LEN*ddr_link_pkg::DQ_W-1:0] i_wdata,
  input wire logic [BURST_LEN*ddr_link_pkg::LANES-1:0] i_wmask,
  output logic o_req_err,
  output logic o_rvalid,
  output logic [BURST_LEN*ddr_link_pkg::DQ_W-1:0] o_rdata
);
  localparam int DQ_W = ddr_link_pkg::DQ_W;
  localparam int LANES = ddr_link_pkg::LANES;
  localparam int CA_W = ddr_link_pkg::CA_W;
  localparam int PH_W = ddr_link_pkg::PH_W;
  localparam int BANKS = 1 << ddr_link_pkg::BANK_W;
  localparam int BEAT_W = $clog2(BURST_LEN + 1);
  localparam int CNT_W = $clog2(WR_LAT + 1);
  localparam logic [BEAT_W-1:0] BEAT_END = BEAT_W'(BURST_LEN);

  typedef enum logic [2:0] {
    C_IDLE = 3'h0,
    C_CMD = 3'h1,
    C_WWAIT = 3'h2,
    C_WDATA = 3'h3,
    C_RDATA = 3'h4
  } cstate_e;

  logic [PH_W-1:0] ph_r, ph_nxt;
  logic ck_r, ck_nxt;
  cstate_e st_r, st_nxt;
  logic cke_r, cke_nxt, cs_n_r, cs_n_nxt;
  logic [CA_W-1:0] ca_r, ca_nxt;
  ddr_link_pkg::cmd_e cmd_r, cmd_nxt;
  logic [ddr_link_pkg::BANK_W-1:0] bank_r, bank_nxt;
  logic [ddr_link_pkg::ROW_W-1:0] addr_r, addr_nxt;
  logic [BURST_LEN*DQ_W-1:0] wdat_r, wdat_nxt;
  logic [BURST_LEN*LANES-1:0] wmsk_r, wmsk_nxt;
  logic [BEAT_W-1:0] beat_r, beat_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [DQ_W-1:0] dq_r, dq_nxt;
  logic [LANES-1:0] dm_r, dm_nxt;
  logic dqs_r, dqs_nxt, oe_r, oe_nxt;
  logic [BANKS-1:0] open_r, open_nxt;
  logic [BURST_LEN*DQ_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt, err_r, err_nxt;
  logic [DQ_W:0] s1_r, s2_r;
  logic dqs_prev_r;
  logic dqs_edge;
  logic take;

  assign dqs_edge = s2_r[DQ_W] ^ dqs_prev_r;
  // Commands leave only where CA is stable around the coming rise
  assign o_req_ready = (st_r == C_IDLE) && (ph_r == ddr_link_pkg::PH_CA_RISE)
    && cke_r && i_cke_en;
  assign take = i_req_valid && o_req_ready;

  always_comb begin
    ph_nxt = (ph_r == ddr_link_pkg::PH_LAST) ? '0 : ph_r + 1'b1;
    ck_nxt = (ph_nxt < PH_W'(ddr_link_pkg::CK_HALF));
    st_nxt = st_r;
    cke_nxt = cke_r;
    cs_n_nxt = cs_n_r;
    ca_nxt = ca_r;
    cmd_nxt = cmd_r;
    bank_nxt = bank_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    wmsk_nxt = wmsk_r;
    beat_nxt = beat_r;
    cnt_nxt = cnt_r;
    dq_nxt = dq_r;
    dm_nxt = dm_r;
    dqs_nxt = dqs_r;
    oe_nxt = oe_r;
    open_nxt = open_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    err_nxt = 1'b0;
    if (ph_r == ddr_link_pkg::PH_CA_RISE) begin
      cs_n_nxt = 1'b1;
      ca_nxt = '0;
    end
    case (st_r)
      C_IDLE: begin
        if (ph_r == ddr_link_pkg::PH_CA_RISE) begin
          cke_nxt = i_cke_en;
        end
        if (take && i_req_cmd != ddr_link_pkg::CMD_ACT
            && !open_r[i_req_bank]) begin
          err_nxt = 1'b1;
        end else if (take) begin
          cs_n_nxt = 1'b0;
          ca_nxt = '0;
          ca_nxt[ddr_link_pkg::OP_LSB +: ddr_link_pkg::OP_W] = i_req_cmd;
          ca_nxt[ddr_link_pkg::BANK_LSB +: ddr_link_pkg::BANK_W] = i_req_bank;
          if (i_req_cmd == ddr_link_pkg::CMD_ACT) begin
            ca_nxt[ddr_link_pkg::ROWHI_LSB +: ddr_link_pkg::ROWHI_W] =
              i_req_addr[ddr_link_pkg::ROW_W-1 -: ddr_link_pkg::ROWHI_W];
          end
          cmd_nxt = i_req_cmd;
          bank_nxt = i_req_bank;
          addr_nxt = i_req_addr;
          wdat_nxt = i_wdata;
          wmsk_nxt = i_wmask;
          st_nxt = C_CMD;
        end
      end
      C_CMD: begin
        if (ph_r == ddr_link_pkg::PH_CA_FALL) begin
          ca_nxt = addr_r[CA_W-1:0];
          beat_nxt = '0;
          cnt_nxt = CNT_W'(WR_LAT);
          case (cmd_r)
            ddr_link_pkg::CMD_ACT: begin
              open_nxt[bank_r] = 1'b1;
              st_nxt = C_IDLE;
            end
            ddr_link_pkg::CMD_WR: st_nxt = C_WWAIT;
            ddr_link_pkg::CMD_RD: st_nxt = C_RDATA;
            default: st_nxt = C_IDLE;
          endcase
        end
      end
      C_WWAIT: begin
        if (ph_r == ddr_link_pkg::PH_DQ_B && cnt_r == CNT_W'(1)) begin
          oe_nxt = 1'b1;
          dqs_nxt = 1'b0;
        end
        if (ph_r == ddr_link_pkg::PH_DQ_A) begin
          if (cnt_r == CNT_W'(1)) begin
            dq_nxt = wdat_r[0 +: DQ_W];
            dm_nxt = wmsk_r[0 +: LANES];
            beat_nxt = BEAT_W'(1);
            st_nxt = C_WDATA;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
      end
      C_WDATA: begin
        if (ph_r == ddr_link_pkg::PH_DQS_A || ph_r == ddr_link_pkg::PH_DQS_B) begin
          dqs_nxt = ~dqs_r;
        end
        if (ph_r == ddr_link_pkg::PH_DQ_A || ph_r == ddr_link_pkg::PH_DQ_B) begin
          if (beat_r == BEAT_END) begin
            oe_nxt = 1'b0;
            dm_nxt = '0;
            st_nxt = C_IDLE;
          end else begin
            dq_nxt = wdat_r[int'(beat_r)*DQ_W +: DQ_W];
            dm_nxt = wmsk_r[int'(beat_r)*LANES +: LANES];
            beat_nxt = beat_r + 1'b1;
          end
        end
      end
      C_RDATA: begin
        if (dqs_edge) begin
          rdata_nxt[int'(beat_r)*DQ_W +: DQ_W] = s2_r[DQ_W-1:0];
          beat_nxt = beat_r + 1'b1;
          if (beat_r == BEAT_END - 1'b1) begin
            rvalid_nxt = 1'b1;
            st_nxt = C_IDLE;
          end
        end
      end
      default: st_nxt = C_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ph_r <= '0;
      ck_r <= 1'b0;
      st_r <= C_IDLE;
      cke_r <= 1'b0;
      cs_n_r <= 1'b1;
      ca_r <= '0;
      cmd_r <= ddr_link_pkg::CMD_NOP;
      bank_r <= '0;
      addr_r <= '0;
      wdat_r <= '0;
      wmsk_r <= '0;
      beat_r <= '0;
      cnt_r <= '0;
      dq_r <= '0;
      dm_r <= '0;
      dqs_r <= 1'b0;
      oe_r <= 1'b0;
      open_r <= '0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      err_r <= 1'b0;
      s1_r <= '0;
      s2_r <= '0;
      dqs_prev_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      ck_r <= ck_nxt;
      st_r <= st_nxt;
      cke_r <= cke_nxt;
      cs_n_r <= cs_n_nxt;
      ca_r <= ca_nxt;
      cmd_r <= cmd_nxt;
      bank_r <= bank_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      wmsk_r <= wmsk_nxt;
      beat_r <= beat_nxt;
      cnt_r <= cnt_nxt;
      dq_r <= dq_nxt;
      dm_r <= dm_nxt;
      dqs_r <= dqs_nxt;
      oe_r <= oe_nxt;
      open_r <= open_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r <= err_nxt;
      s1_r <= {lnk.dqs_t[0], lnk.dq};
      s2_r <= s1_r;
      dqs_prev_r <= s2_r[DQ_W];
    end
  end

  assign lnk.ck_t = ck_r;
  assign lnk.ck_c = ~ck_r;
  assign lnk.cke = cke_r;
  assign lnk.cs_n = cs_n_r;
  assign lnk.ca = ca_r;
  assign lnk.dm = dm_r;
  assign lnk.ctl_dq = dq_r;
  assign lnk.ctl_dq_oe = oe_r;
  assign lnk.ctl_dqs_t = {LANES{dqs_r}};
  assign lnk.ctl_dqs_c = {LANES{~dqs_r}};
  assign lnk.ctl_dqs_oe = oe_r;
  assign o_req_err = err_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
endmodule : ddr_ctl_end

// ===== ddr_link_sva.sv
// Wire-level assertions for the DDR command/data link
`timescale 1ns/100ps
module ddr_link_sva (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic ck_t,
  input wire logic ck_c,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [9:0] ca,
  input wire logic [31:0] dq,
  input wire logic [3:0] dqs_t,
  input wire logic [3:0] dqs_c,
  input wire logic ctl_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic ctl_dqs_oe,
  input wire logic dev_dqs_oe
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  sequence s_ck_edge;
    $rose(ck_t) || $fell(ck_t);
  endsequence
  sequence s_cmd_hold;
    (!cs_n)[*7];
  endsequence
  // Eight cycles covers one full link clock period
  sequence s_parked;
    (!cke)[*8];
  endsequence

  a_ca_both_edges: assert property (s_ck_edge |-> $stable(ca))
    else $error("ca moved at a link clock edge");
  a_ck_pair: assert property (ck_c == !ck_t)
    else $error("link clock pair not complementary");
  a_cs_cke_rise: assert property (
    $rose(ck_t) |-> $stable(cs_n) && $stable(cke))
    else $error("cs_n or cke moved at clock rise");
  a_parked_quiet: assert property (
    s_parked |-> !dev_dq_oe && !dev_dqs_oe)
    else $error("device drives while cke low");
  a_cmd_one_cycle: assert property ($fell(cs_n) |=> s_cmd_hold)
    else $error("command select shorter than one clock");
  a_one_talker: assert property (
    !(dev_dq_oe && ctl_dq_oe) && !(dev_dqs_oe && ctl_dqs_oe))
    else $error("both ends drive the data lines");
  a_wr_centred: assert property (
    ctl_dqs_oe && !dev_dqs_oe && $changed(dqs_t) |-> $stable(dq))
    else $error("write data moved at strobe edge");
  a_rd_aligned: assert property (
    dev_dq_oe && $past(dev_dq_oe) && $changed(dq) |-> $changed(dqs_t))
    else $error("read data moved without strobe edge");
  a_dqs_pair: assert property (
    dev_dqs_oe || ctl_dqs_oe |-> dqs_c == ~dqs_t)
    else $error("strobe pair not complementary");
  a_beat_hold: assert property (
    ctl_dq_oe && $changed(dq) |=> $stable(dq)[*3])
    else $error("write beat shorter than half clock");
endmodule : ddr_link_sva

// ===== tb.sv
// Self-checking bench joining controller and device ends
`timescale 1ns/100ps
module tb;
  localparam int W = 128;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic cke_en = 1'b0;
  logic req_valid = 1'b0;
  ddr_link_pkg::cmd_e req_cmd = ddr_link_pkg::CMD_NOP;
  logic [2:0] req_bank = 3'h0;
  logic [13:0] req_addr = 14'h0;
  logic [W-1:0] wdata = '0;
  logic [15:0] wmask = 16'h0;
  logic req_ready, req_err, rvalid, power_down, cmd_valid;
  logic [W-1:0] rdata;
  ddr_link_pkg::cmd_e cmd;
  logic [2:0] cmd_bank;
  logic [13:0] cmd_addr;
  int failures = 0, n_compared = 0, n_cmds = 0, n_seen = 0;
  logic [15:0] seed = 16'hcefc;

  ddr_link_if lnk_if ();
  ddr_ctl_end ddr_ctl_end_i (.lnk(lnk_if.ctl), .i_clk(i_clk),
    .i_srst(i_srst), .i_cke_en(cke_en), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .i_req_cmd(req_cmd), .i_req_bank(req_bank),
    .i_req_addr(req_addr), .i_wdata(wdata), .i_wmask(wmask),
    .o_req_err(req_err), .o_rvalid(rvalid), .o_rdata(rdata));
  ddr_dev_end ddr_dev_end_i (.lnk(lnk_if.dev), .i_clk(i_clk),
    .i_srst(i_srst), .o_power_down(power_down), .o_cmd_valid(cmd_valid),
    .o_cmd(cmd), .o_cmd_bank(cmd_bank), .o_cmd_addr(cmd_addr));
  ddr_link_sva ddr_link_sva_i (.i_clk(i_clk), .i_srst(i_srst),
    .ck_t(lnk_if.ck_t), .ck_c(lnk_if.ck_c), .cke(lnk_if.cke),
    .cs_n(lnk_if.cs_n), .ca(lnk_if.ca), .dq(lnk_if.dq),
    .dqs_t(lnk_if.dqs_t), .dqs_c(lnk_if.dqs_c),
    .ctl_dq_oe(lnk_if.ctl_dq_oe), .dev_dq_oe(lnk_if.dev_dq_oe),
    .ctl_dqs_oe(lnk_if.ctl_dqs_oe), .dev_dqs_oe(lnk_if.dev_dqs_oe));

  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // Counted at the falling edge, away from the launching edge, so the pulse is settled
  always @(negedge i_clk) begin
    if (!i_srst && cmd_valid === 1'b1) n_seen++;
  end

  task chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task report_and_stop;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Bounded wait; an expired wait ends the run
  task automatic wait_hi(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(negedge i_clk);
      n++;
    end
    if (s !== v) begin
      chk(v, ~v);
      report_and_stop;
    end
  endtask : wait_hi

  function automatic logic [W-1:0] rnd();
    logic [W-1:0] v;
    v = '0;
    for (int i = 0; i < 8; i++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      v = {v[W-17:0], seed};
    end
    return v;
  endfunction : rnd

  function logic [W-1:0] merge(input logic [W-1:0] o, input logic [W-1:0] d,
                               input logic [15:0] mk);
    for (int i = 0; i < 16; i++) merge[8*i+:8] = mk[i] ? o[8*i+:8] : d[8*i+:8];
  endfunction : merge

  // Request held from negedge until taken at a rising edge
  task req(input ddr_link_pkg::cmd_e c, input logic [2:0] b,
           input logic [13:0] a);
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_valid = 1'b1;
    // Ready is looked at mid-cycle, where it has settled
    for (int n = 0; n < 400; n++) begin
      @(negedge i_clk);
      if (req_ready === 1'b1) break;
    end
    if (req_ready !== 1'b1) begin
      chk(1'b0, 1'b1);
      report_and_stop;
    end
    @(posedge i_clk);
    @(negedge i_clk);
    req_valid = 1'b0;
  endtask : req

  task req_cmd_chk(input ddr_link_pkg::cmd_e c, input logic [2:0] b,
                   input logic [13:0] a);
    req(c, b, a);
    wait_hi(cmd_valid, 1'b1);
    n_cmds++;
    chk(cmd, c);
    chk(cmd_bank, b);
    chk(cmd_addr, a);
  endtask : req_cmd_chk

  initial begin
    logic [W-1:0] d1, d2, m, exp;
    logic [2:0] b;
    logic [13:0] col;
    repeat (2) @(negedge i_clk);
    i_srst = 1'b0;
    cke_en = 1'b1;
    wait_hi(power_down, 1'b0);
    req(ddr_link_pkg::CMD_RD, 3'h2, 14'h0);
    wait_hi(req_err, 1'b1);
    for (int k = 0; k < 6; k++) begin
      d1 = rnd();
      d2 = rnd();
      m = rnd();
      b = d1[2:0];
      // Top column first, so the burst wraps at the end of its block
      col = (k == 0) ? 14'h3ff : {4'h0, d2[9:0]};
      req_cmd_chk(ddr_link_pkg::CMD_ACT, b, d1[16:3]);
      wdata = d1;
      wmask = 16'h0;
      req_cmd_chk(ddr_link_pkg::CMD_WR, b, col);
      wdata = d2;
      wmask = m[15:0];
      req_cmd_chk(ddr_link_pkg::CMD_WR, b, col);
      req_cmd_chk(ddr_link_pkg::CMD_RD, b, col);
      wait_hi(rvalid, 1'b1);
      exp = merge(d1, d2, m[15:0]);
      chk(rdata, exp);
    end
    cke_en = 1'b0;
    wait_hi(power_down, 1'b1);
    cke_en = 1'b1;
    wait_hi(power_down, 1'b0);
    req_cmd_chk(ddr_link_pkg::CMD_RD, b, col);
    wait_hi(rvalid, 1'b1);
    chk(rdata, exp);
    repeat (20) @(negedge i_clk);
    chk(n_seen, n_cmds);
    report_and_stop;
  end
endmodule : tb
